/* File: arcs_consts.vh */
// constants for the acquisition run control and status byte
// assumes the host port strobes and the mode/clear inputs share clk_i
// Behaviour
// [RQ1] byte sits in low eight data bits
// [RQ2] active 0/1, sync 4/5, done/stop 6/7
// [RQ3] active reads 1 while acquisition runs
// [RQ4] writing 0 to active changes nothing
// [RQ5] writing 1 starts only when idle
// [RQ6] start only in continuous or single-pass mode
// [RQ7] single-pass ends on chosen buffer flag
// [RQ8] stop bit aborts, clears active/done/pacer fault; code accepts it only in continuous and single-pass modes
// [RQ9] writing 0 to stop bit changes nothing
// [RQ10] buffer clear writes abort and clear bits
// [RQ11] configuration mode aborts and clears bits
// [RQ12] bits 6/7 stop on write, done on read
// [RQ13] done reads 1 only after normal end
// [RQ14] sync seen forced 0 while inactive
// [RQ15] sync seen sets once event detected
// [RQ16] reset clears active, sync and done bits
// [RQ17] mode codes: config, reserved, continuous, single-pass
// [RQ18] continuous mode keeps running on buffer errors
// [RQ19] stop flag choice picks full or almost flag
`ifndef ARCS_CONSTS_VH
`define ARCS_CONSTS_VH
`define ARCS_BIT_ADC_ACTIVE 0
`define ARCS_BIT_DAC_ACTIVE 1
`define ARCS_BIT_ADC_SYNC 4
`define ARCS_BIT_DAC_SYNC 5
`define ARCS_BIT_ADC_DONE 6
`define ARCS_BIT_DAC_DONE 7
`define ARCS_MODE_CONFIG 2'h0
`define ARCS_MODE_RESERVED 2'h1
`define ARCS_MODE_CONTINUOUS 2'h2
`define ARCS_MODE_SINGLE 2'h3
`define ARCS_RST_STATUS 8'h00
`endif

/* File: arcs_direction.v */
// one direction's acquisition run controller
// assumes all inputs are on clk_i and strobes are one-cycle pulses
`include "arcs_consts.vh"
`default_nettype none
module arcs_direction (
    input wire clk_i,           // clock
    input wire sys_rst_i,       // async reset, high
    input wire [1:0] mode_i,    // mode field
    input wire start_i,         // host wrote 1 to active
    input wire stop_i,          // host wrote 1 to stop
    input wire clear_i,         // buffer clear write
    input wire term_flag_i,     // selected termination flag
    input wire sync_i,          // sync event
    output reg active_o,        // acquisition running
    output reg done_o,          // normal end seen
    output reg sync_seen_o,     // sync seen in this run
    output reg fault_clr_o      // pacer fault clear pulse
);
    // ------------------------------------------------------------
    // run state
    // ------------------------------------------------------------
    // [RQ17] mode code decode
    wire acq_mode = (mode_i == `ARCS_MODE_CONTINUOUS) || (mode_i == `ARCS_MODE_SINGLE);
    // [RQ8] stop in acquisition modes
    wire stop_ok = stop_i && acq_mode;
    // [RQ11] configuration mode abort
    wire cfg_abort = (mode_i == `ARCS_MODE_CONFIG);
    // [RQ7] single-pass normal end
    wire normal_end = active_o && (mode_i == `ARCS_MODE_SINGLE) && term_flag_i;
    wire kill = stop_ok || clear_i || cfg_abort;
    // state update; aborts win over start and end
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // [RQ16] reset clears status
            active_o <= 1'b0;
            done_o <= 1'b0;
            sync_seen_o <= 1'b0;
            fault_clr_o <= 1'b0;
        end else begin
            fault_clr_o <= stop_ok;
            if (kill) begin
                // [RQ10] clear and abort
                active_o <= 1'b0;
                done_o <= 1'b0;
            end else if (normal_end) begin
                // [RQ13] done only after normal end
                active_o <= 1'b0;
                done_o <= 1'b1;
            end else if (start_i && !active_o && acq_mode) begin
                // [RQ5] [RQ6] start when idle in acquisition mode
                active_o <= 1'b1;
                done_o <= 1'b0;
            end
            // [RQ14] [RQ15] sync seen only during a run
            if (kill || normal_end || !active_o)
                sync_seen_o <= 1'b0;
            else if (sync_i)
                sync_seen_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: arcs_top.v */
// acquisition run control and status byte on the host expansion port
// assumes write/read strobes are one-cycle pulses on clk_i; pins synced here
`include "arcs_consts.vh"
`default_nettype none
module arcs_top (
    input wire clk_i,                  // 10 MHz clock
    input wire sys_rst_i,              // async reset, high
    input wire wr_stb_i,               // register write strobe
    input wire rd_stb_i,               // register read strobe
    input wire [15:0] wr_data_i,       // host write data
    input wire [1:0] adc_mode_i,       // adc mode field
    input wire [1:0] dac_mode_i,       // dac mode field
    input wire adc_stop_flag_choice_i, // 0 full, 1 almost full
    input wire dac_stop_flag_choice_i, // 0 empty, 1 almost empty
    input wire adc_clear_i,            // adc buffer clear write
    input wire dac_clear_i,            // dac buffer clear write
    input wire all_clear_i,            // common buffer clear write
    input wire adc_full_flag_i,        // adc buffer full pin
    input wire adc_almost_full_flag_i, // adc buffer almost full pin
    input wire dac_empty_flag_i,       // dac buffer empty pin
    input wire dac_almost_empty_flag_i,// dac buffer almost empty pin
    input wire adc_sync_i,             // adc sync event pin
    input wire dac_sync_i,             // dac sync event pin
    output reg [15:0] rd_data_o,       // host read data
    output reg adc_acq_active_o,       // adc running
    output reg dac_acq_active_o,       // dac running
    output reg adc_pacer_fault_clr_o,  // adc pacer fault clear
    output reg dac_pacer_fault_clr_o   // dac pacer fault clear
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [5:0] pin_s1_reg;
    reg [5:0] pin_s2_reg;
    // two flops per pin flag and sync input
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_reg <= 6'h00;
            pin_s2_reg <= 6'h00;
        end else begin
            pin_s1_reg <= {dac_sync_i, adc_sync_i, dac_almost_empty_flag_i,
                           dac_empty_flag_i, adc_almost_full_flag_i, adc_full_flag_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // [RQ4] [RQ9] zero bits cause nothing
    wire adc_start = wr_stb_i && wr_data_i[`ARCS_BIT_ADC_ACTIVE];
    wire dac_start = wr_stb_i && wr_data_i[`ARCS_BIT_DAC_ACTIVE];
    // [RQ12] bits 6/7 act as stop on write
    wire adc_stop = wr_stb_i && wr_data_i[`ARCS_BIT_ADC_DONE];
    wire dac_stop = wr_stb_i && wr_data_i[`ARCS_BIT_DAC_DONE];
    // [RQ19] termination flag choice
    wire adc_term = adc_stop_flag_choice_i ? pin_s2_reg[1] : pin_s2_reg[0];
    wire dac_term = dac_stop_flag_choice_i ? pin_s2_reg[3] : pin_s2_reg[2];
    wire adc_act;
    wire dac_act;
    wire adc_done;
    wire dac_done;
    wire adc_sync;
    wire dac_sync;
    wire adc_fclr;
    wire dac_fclr;
    // [RQ18] errors never reach the run control
    arcs_direction u_adc (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .mode_i(adc_mode_i),
        .start_i(adc_start),
        .stop_i(adc_stop),
        .clear_i(adc_clear_i | all_clear_i),
        .term_flag_i(adc_term),
        .sync_i(pin_s2_reg[4]),
        .active_o(adc_act),
        .done_o(adc_done),
        .sync_seen_o(adc_sync),
        .fault_clr_o(adc_fclr)
    );
    arcs_direction u_dac (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .mode_i(dac_mode_i),
        .start_i(dac_start),
        .stop_i(dac_stop),
        .clear_i(dac_clear_i | all_clear_i),
        .term_flag_i(dac_term),
        .sync_i(pin_s2_reg[5]),
        .active_o(dac_act),
        .done_o(dac_done),
        .sync_seen_o(dac_sync),
        .fault_clr_o(dac_fclr)
    );
    // ------------------------------------------------------------
    // read back and outputs
    // ------------------------------------------------------------
    // [RQ1] [RQ2] [RQ3] status byte in low bits
    wire [7:0] status = {dac_done, adc_done, dac_sync, adc_sync, 2'h0, dac_act, adc_act};
    // registered outputs
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 16'h0000;
            adc_acq_active_o <= 1'b0;
            dac_acq_active_o <= 1'b0;
            adc_pacer_fault_clr_o <= 1'b0;
            dac_pacer_fault_clr_o <= 1'b0;
        end else begin
            if (rd_stb_i)
                rd_data_o <= {8'h00, status};
            adc_acq_active_o <= adc_act;
            dac_acq_active_o <= dac_act;
            adc_pacer_fault_clr_o <= adc_fclr;
            dac_pacer_fault_clr_o <= dac_fclr;
        end
    end
endmodule
`default_nettype wire

/* File: arcs_asserts.sv */
// checker for the acquisition run control and status byte
// assumes it is bound to arcs_top and sees only its ports
`default_nettype none
module arcs_asserts (
    input wire logic clk_i, sys_rst_i, wr_stb_i, rd_stb_i, // clock, reset, strobes
    input wire logic [15:0] wr_data_i, rd_data_o, // host data both ways
    input wire logic [1:0] adc_mode_i, dac_mode_i, // mode fields
    input wire logic adc_clear_i, all_clear_i, // buffer clear writes
    input wire logic adc_acq_active_o, dac_acq_active_o, // running copies
    input wire logic adc_pacer_fault_clr_o, dac_pacer_fault_clr_o // fault clear pulses
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // accepted stop write toward the adc side
    wire adc_stop = wr_stb_i & wr_data_i[6] & adc_mode_i[1];
    a_stop_idles_adc: assert property (adc_stop |-> ##2 !adc_acq_active_o)
        else $error("adc still running after stop");
    a_stop_pulse_dac: assert property (wr_stb_i && wr_data_i[7] && dac_mode_i[1]
        |-> ##2 dac_pacer_fault_clr_o) else $error("no dac fault clear");
    a_pulse_cause: assert property (adc_pacer_fault_clr_o |-> $past(adc_stop, 2))
        else $error("adc fault clear without stop");
    a_start_runs: assert property (wr_stb_i && wr_data_i[0] && !wr_data_i[6]
        && adc_mode_i == 2'h2 && !adc_clear_i && !all_clear_i |-> ##2 adc_acq_active_o)
        else $error("adc start ignored");
    a_cfg_aborts: assert property (dac_mode_i == 2'h0 [*4] |-> !dac_acq_active_o)
        else $error("dac runs in config mode");
    a_clear_aborts: assert property (adc_clear_i || all_clear_i |-> ##2 !adc_acq_active_o)
        else $error("adc runs after buffer clear");
    a_read_zeros: assert property (rd_stb_i |=> rd_data_o[15:8] == 8'h00
        && rd_data_o[3:2] == 2'h0) else $error("undefined read bits set");
    a_read_hold: assert property (!rd_stb_i |=> $stable(rd_data_o))
        else $error("read data moved without read");
    a_sync_run: assert property ((rd_data_o[5:4] & ~rd_data_o[1:0]) == 2'h0)
        else $error("sync seen while idle");
    a_done_idle: assert property ((rd_data_o[7:6] & rd_data_o[1:0]) == 2'h0)
        else $error("done while running");
endmodule
bind arcs_top arcs_asserts u_chk (.*);
`default_nettype wire

/* File: arcs_host.sv */
// host processor model driving the register write and read strobes
// assumes callers start each access at a falling edge
`default_nettype none
module arcs_host (
    input wire logic clk_i, // clock
    input wire logic [15:0] rd_data_i, // read data
    output var logic wr_stb_o, // write strobe
    output var logic rd_stb_o, // read strobe
    output var logic [15:0] wr_data_o // write data
);
    initial begin
        wr_stb_o = 1'b0;
        rd_stb_o = 1'b0;
        wr_data_o = 16'h0000;
    end
    // one write, idle bus then shows the inverse of the last value
    task automatic wr(input logic [15:0] v);
        @(negedge clk_i) {wr_stb_o, wr_data_o} = {1'b1, v};
        @(negedge clk_i) {wr_stb_o, wr_data_o} = {1'b0, ~v};
    endtask
    // one read, data taken one cycle after the strobe
    task automatic rd(output logic [15:0] v);
        @(negedge clk_i) rd_stb_o = 1'b1;
        @(negedge clk_i) rd_stb_o = 1'b0;
        @(negedge clk_i) v = rd_data_i;
    endtask
endmodule
`default_nettype wire

/* File: tb_acquisition_run_control_status.sv */
// testbench for the acquisition run control and status byte
// assumes arcs_top, arcs_host and the bound checker are compiled first
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_acquisition_run_control_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1;
    logic [3:0] mode = 0, flg = 0;
    logic [2:0] clr = 0;
    logic [1:0] ch = 0, syn = 0, act, fc;
    int n_fc0 = 0, n_fc1 = 0;
    logic wr_stb, rd_stb;
    logic [15:0] wr_data, rd_data, r;
    int n_mismatch = 0, n_checks = 0, seed = 40, cyc = 0;
    initial forever #50 clk_i = ~clk_i;
    arcs_host u_host (.clk_i(clk_i), .rd_data_i(rd_data), .wr_stb_o(wr_stb),
        .rd_stb_o(rd_stb), .wr_data_o(wr_data));
    arcs_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_stb_i(wr_stb),
        .rd_stb_i(rd_stb), .wr_data_i(wr_data), .adc_mode_i(mode[1:0]), .dac_mode_i(mode[3:2]),
        .adc_stop_flag_choice_i(ch[0]), .dac_stop_flag_choice_i(ch[1]), .adc_clear_i(clr[0]),
        .dac_clear_i(clr[1]), .all_clear_i(clr[2]), .adc_full_flag_i(flg[0]),
        .adc_almost_full_flag_i(flg[1]), .dac_empty_flag_i(flg[2]),
        .dac_almost_empty_flag_i(flg[3]), .adc_sync_i(syn[0]), .dac_sync_i(syn[1]),
        .rd_data_o(rd_data), .adc_acq_active_o(act[0]), .dac_acq_active_o(act[1]),
        .adc_pacer_fault_clr_o(fc[0]), .dac_pacer_fault_clr_o(fc[1]));
    // count fault clear pulses away from the launching edge
    always @(negedge clk_i) begin
        if (fc[0] === 1'b1) n_fc0++;
        if (fc[1] === 1'b1) n_fc1++;
    end
    // expected active, sync, done and zero fields of one direction
    function automatic logic [12:0] expv(logic a, logic s, logic dn);
        return {a, s, dn, 10'h000};
    endfunction
    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_n(int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic st(int d, logic a, logic s, logic dn);
        u_host.rd(r);
        `CHK("status", expv(a, s, dn), {r[d], r[4+d], r[6+d], r[15:8], r[3:2]})
        `CHK("active out", a, act[d])
    endtask
    always @(posedge clk_i) if (++cyc > 5000) begin n_mismatch++; conclude(); end
    initial begin
        wait_n(8);
        sys_rst_i = 0;
        for (int d = 0; d < 2; d++) st(d, 0, 0, 0);
        for (int d = 0; d < 2; d++) begin
            for (int m = 0; m < 4; m++) begin
                mode[2*d+:2] = m[1:0];
                u_host.wr(16'h1 << d);
                st(d, m[1], 0, 0);
                u_host.wr(16'h40 << d);
                st(d, 0, 0, 0);
            end
            // continuous run with random ignored bits and flags all high
            mode[2*d+:2] = 2;
            flg = 4'hF;
            u_host.wr(16'(($random(seed) & 16'hFF3C) | (16'h1 << d)));
            wait_n(5);
            st(d, 1, 0, 0);
            syn[d] = 1;
            wait_n(4);
            syn[d] = 0;
            u_host.wr(16'h0000);
            u_host.wr(16'h1 << d);
            st(d, 1, 1, 0);
            clr[d] = 1;
            @(negedge clk_i) clr = 0;
            st(d, 0, 0, 0);
            u_host.wr(16'h1 << d);
            clr[2] = 1;
            @(negedge clk_i) clr = 0;
            st(d, 0, 0, 0);
            // single pass ending on the chosen flag only
            for (int c = 0; c < 2; c++) begin
                mode[2*d+:2] = 3;
                flg = 0;
                ch[d] = c[0];
                wait_n(3);
                u_host.wr(16'h1 << d);
                flg[2*d+1-c] = 1;
                wait_n(5);
                st(d, 1, 0, 0);
                flg[2*d+c] = 1;
                wait_n(5);
                st(d, 0, 0, 1);
                if (c == 0) u_host.wr(16'h40 << d);
                else begin mode[2*d+:2] = 0; wait_n(2); end
                st(d, 0, 0, 0);
            end
        end
        // stops in modes 2 and 3 plus one single-pass stop per direction
        wait_n(4);
        `CHK("adc fault clears", 3, n_fc0)
        `CHK("dac fault clears", 3, n_fc1)
        conclude();
    end
endmodule
`default_nettype wire
